// ---- hdl/sarcc_pkg.sv ----
package sarcc_pkg;

  localparam int unsigned CLK_MHZ       = 50;
  localparam int unsigned CONV_TIME_NS  = 7000;
  localparam int unsigned ACQ_TIME_NS   = 1000;
  localparam int unsigned START_LOW_NS  = 40;
  localparam int unsigned SETUP_RC_NS   = 10;
  localparam int unsigned RC_RETURN_NS  = 3000;
  localparam int unsigned DATA_W        = 16;
  localparam int unsigned BYTE_W        = 8;

  // least times round up, longest times round down
  localparam int unsigned CONV_CYC  = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned ACQ_CYC   = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned LOW_CYC   = (START_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETUP_CYC = (SETUP_RC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned RET_CYC   = (RC_RETURN_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W     = 9;

  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [CNT_W-1:0] ACQ_LAST  = CNT_W'(ACQ_CYC - 1);
  localparam logic [CNT_W-1:0] LOW_LAST  = CNT_W'(LOW_CYC - 1);
  localparam logic [CNT_W-1:0] RET_LAST  = CNT_W'(RET_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // place the two result bytes on the lanes
  function automatic logic [DATA_W-1:0] sarcc_lanes
  (
    input logic [DATA_W-1:0] word,
    input logic              swap
  );
    sarcc_lanes = swap ? {word[BYTE_W-1:0], word[DATA_W-1:BYTE_W]} : word;
  endfunction : sarcc_lanes

endpackage : sarcc_pkg

// ---- hdl/sarcc_if.sv ----
`timescale 1ns/1ps
interface sarcc_if;
  logic        sel_n;
  logic        rd_conv_n;
  logic        busy_n;
  logic        byte_swap;
  logic [15:0] data_out;
  logic [15:0] data_oe;

  modport dev
  (
    input  sel_n,
    input  rd_conv_n,
    input  byte_swap,
    output busy_n,
    output data_out,
    output data_oe
  );

  modport host
  (
    output sel_n,
    output rd_conv_n,
    output byte_swap,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface : sarcc_if

// ---- hdl/sarcc_device.sv ----
`timescale 1ns/1ps
module sarcc_device
  import sarcc_pkg::*;
(
  input  wire logic              clk,         // 50 MHz clock
  input  wire logic              sys_rst,     // sync reset, high
  sarcc_if.dev                   port,        // host-facing pins
  input  wire logic [DATA_W-1:0] sample,      // two's complement result
  output logic                   hold,        // sample-and-hold in hold
  output logic                   conv_done    // pulse when result latched
);

  typedef enum logic [0:0] {SARCC_IDLE, SARCC_CONV} sarcc_dev_st_t;

  sarcc_dev_st_t     state;
  logic [CNT_W-1:0]  cnt;
  logic [DATA_W-1:0] result;
  logic              busy_n;
  logic [DATA_W-1:0] data_out;
  logic [DATA_W-1:0] data_oe;
  logic              prev_low;

  // sel_n is or'd with rd_conv_n: a falling edge of the or starts
  wire start_low   = ~port.sel_n & ~port.rd_conv_n;
  wire start_edge  = start_low & ~prev_low;
  wire start       = start_edge & (state == SARCC_IDLE);
  wire conv_end    = (state == SARCC_CONV) && (cnt == CONV_LAST);
  wire out_en      = ~port.sel_n & port.rd_conv_n;
  wire [DATA_W-1:0] lanes = sarcc_lanes(result, port.byte_swap);

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state     <= SARCC_IDLE;
      cnt       <= CNT_ZERO;
      result    <= DATA_RST;
      busy_n    <= 1'b1;
      hold      <= 1'b0;
      conv_done <= 1'b0;
      prev_low  <= 1'b0;
      data_out  <= DATA_RST;
      data_oe   <= DATA_RST;
    end
    else
    begin
      prev_low  <= start_low;
      conv_done <= conv_end;
      case (state)
        SARCC_IDLE:
        begin
          if (start)
          begin
            state  <= SARCC_CONV;
            cnt    <= CNT_ZERO;
            busy_n <= 1'b0;
            hold   <= 1'b1;
          end
        end
        SARCC_CONV:
        begin
          cnt <= cnt + 9'h001;
          if (conv_end)
          begin
            result <= sample;
            state  <= SARCC_IDLE;
            busy_n <= 1'b1;
            hold   <= 1'b0;
          end
        end
        default: state <= SARCC_IDLE;
      endcase
      // drives when sel_n low and rd_conv_n high: read or rising edge
      data_out <= lanes;
      data_oe  <= {DATA_W{out_en}};
    end
  end

  assign port.busy_n   = busy_n;
  assign port.data_out = data_out;
  assign port.data_oe  = data_oe;

endmodule : sarcc_device

// ---- hdl/sarcc_host.sv ----
`timescale 1ns/1ps
module sarcc_host
  import sarcc_pkg::*;
(
  input  wire logic              clk,        // 50 MHz clock
  input  wire logic              sys_rst,    // sync reset, high
  sarcc_if.host                  port,       // converter pins
  input  wire logic              go,         // pulse: convert and read
  input  wire logic              mode_sel,   // 0 rd_conv_n starts, 1 sel_n
  input  wire logic              swap_req,   // read with byte_swap high
  output logic [DATA_W-1:0]      rd_data,    // word read back
  output logic                   rd_valid,   // pulse with rd_data
  output logic                   ready       // idle, go accepted
);

  typedef enum logic [2:0]
  {
    SARCC_H_IDLE, SARCC_H_SETUP, SARCC_H_LOW, SARCC_H_WAIT,
    SARCC_H_READ, SARCC_H_ACQ
  } sarcc_host_st_t;

  sarcc_host_st_t   state;
  logic [CNT_W-1:0] cnt;
  logic             mode;
  logic             busy_m;
  logic             busy_s;
  logic             busy_seen;
  logic             sel_n;
  logic             rd_conv_n;
  logic             byte_swap;

  wire busy_low = ~busy_s;
  // undriven lanes read low, as if pulled down
  wire [DATA_W-1:0] bus_word = port.data_out & port.data_oe;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      busy_m <= 1'b1;
      busy_s <= 1'b1;
    end
    else
    begin
      busy_m <= port.busy_n;
      busy_s <= busy_m;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state     <= SARCC_H_IDLE;
      cnt       <= CNT_ZERO;
      mode      <= 1'b0;
      busy_seen <= 1'b0;
      sel_n     <= 1'b1;
      rd_conv_n <= 1'b1;
      byte_swap <= 1'b0;
      rd_data   <= DATA_RST;
      rd_valid  <= 1'b0;
      ready     <= 1'b1;
    end
    else
    begin
      rd_valid <= 1'b0;
      cnt      <= cnt + 9'h001;
      case (state)
        SARCC_H_IDLE:
        begin
          if (go)
          begin
            mode      <= mode_sel;
            byte_swap <= swap_req;
            ready     <= 1'b0;
            cnt       <= CNT_ZERO;
            rd_conv_n <= 1'b0;
            sel_n     <= mode_sel;
            state     <= mode_sel ? SARCC_H_SETUP : SARCC_H_LOW;
          end
        end
        SARCC_H_SETUP:
        begin
          sel_n <= 1'b0;
          cnt   <= CNT_ZERO;
          state <= SARCC_H_LOW;
        end
        SARCC_H_LOW:
        begin
          if (cnt == LOW_LAST)
          begin
            sel_n     <= mode;
            rd_conv_n <= 1'b1;
            busy_seen <= 1'b0;
            cnt       <= CNT_ZERO;
            state     <= SARCC_H_WAIT;
          end
        end
        SARCC_H_WAIT:
        begin
          if (busy_low)
            busy_seen <= 1'b1;
          // a line stays high while busy_n rises
          if (busy_seen && !busy_low)
          begin
            sel_n <= 1'b0;
            cnt   <= CNT_ZERO;
            state <= SARCC_H_READ;
          end
        end
        SARCC_H_READ:
        begin
          if (cnt == LOW_LAST)
          begin
            rd_data  <= bus_word;
            rd_valid <= 1'b1;
            sel_n    <= mode;
            cnt      <= CNT_ZERO;
            state    <= SARCC_H_ACQ;
          end
        end
        SARCC_H_ACQ:
        begin
          if (cnt == ACQ_LAST)
          begin
            ready <= 1'b1;
            state <= SARCC_H_IDLE;
          end
        end
        default: state <= SARCC_H_IDLE;
      endcase
    end
  end

  assign port.sel_n     = sel_n;
  assign port.rd_conv_n = rd_conv_n;
  assign port.byte_swap = byte_swap;

endmodule : sarcc_host

// ---- testbench/sarcc_asserts.sv ----
`timescale 1ns/1ps
module sarcc_asserts
  import sarcc_pkg::*;
(
  input wire logic        clk,        // clock
  input wire logic        sys_rst,    // sync reset
  input wire logic        sel_n,      // select
  input wire logic        rd_conv_n,  // read/convert
  input wire logic        busy_n,     // busy
  input wire logic        byte_swap,  // lane swap
  input wire logic [15:0] data_out,   // lane data
  input wire logic [15:0] data_oe     // lane enables
);
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] rd_low_cnt;
  wire              ctl = sel_n | rd_conv_n;

  // cycles of busy_n low so far
  always_ff @(posedge clk)
    low_cnt <= (sys_rst | busy_n) ? CNT_ZERO : low_cnt + 9'h001;

  // cycles of rd_conv_n low so far
  always_ff @(posedge clk)
    rd_low_cnt <= (sys_rst | rd_conv_n) ? CNT_ZERO : rd_low_cnt + 9'h001;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_start;
    ctl ##1 !ctl;
  endsequence

  a_busy_falls: assert property (busy_n throughout s_start |=> !busy_n)
    else $error("busy_n did not fall after a start");
  a_busy_length: assert property ($rose(busy_n) |-> low_cnt == 9'(CONV_CYC))
    else $error("conversion length wrong");
  a_no_restart: assert property (!busy_n |-> low_cnt < 9'(CONV_CYC))
    else $error("busy_n low too long");
  a_start_cause: assert property ($fell(busy_n) |-> $past(!ctl) && $past(ctl, 2))
    else $error("busy_n fell without a start edge");
  a_float_conv: assert property (!rd_conv_n |=> data_oe == 16'h0000)
    else $error("outputs driven while converting");
  a_float_desel: assert property (sel_n |=> data_oe == 16'h0000)
    else $error("outputs driven while deselected");
  a_drive_read: assert property (!sel_n && rd_conv_n |=> data_oe == 16'hFFFF)
    else $error("outputs not driven during read");
  a_data_steady: assert property (data_oe == 16'hFFFF && $past(data_oe) == 16'hFFFF
    && $stable(byte_swap) && $past(busy_n, 2) && busy_n |-> $stable(data_out))
    else $error("read data changed during read");
  a_start_width: assert property ($fell(ctl) |-> !ctl ##1 !ctl)
    else $error("start low pulse too short");
  a_select_width: assert property ($fell(sel_n) |-> !sel_n ##1 !sel_n)
    else $error("sel_n low pulse too short");
  a_line_high: assert property ($rose(busy_n) |-> ctl)
    else $error("both lines low as busy_n rose");
  a_release_time: assert property (rd_low_cnt < 9'(RET_CYC))
    else $error("rd_conv_n held low too long");
endmodule : sarcc_asserts

// ---- testbench/sarcc_test.sv ----
`timescale 1ns/1ps
module sarcc_test;
  import sarcc_pkg::*;
  logic              clk;
  logic              sys_rst;
  logic              go;
  logic              mode_sel;
  logic              swap_req;
  logic [DATA_W-1:0] sample;
  logic [DATA_W-1:0] rd_data;
  logic              hold;
  logic              conv_done;
  int                n_done = 0;
  int                n_runs;
  logic              rd_valid;
  logic              ready;
  int                miscompares;
  int                n_checks;
  logic [15:0]       corner [4] = '{16'h8000, 16'h7FFF, 16'hFFFF, 16'h0001};

  sarcc_if bus ();
  sarcc_device i_sarcc_device (.clk(clk), .sys_rst(sys_rst), .port(bus),
    .sample(sample), .hold(hold), .conv_done(conv_done));
  sarcc_host i_sarcc_host (.clk(clk), .sys_rst(sys_rst), .port(bus), .go(go),
    .mode_sel(mode_sel), .swap_req(swap_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .ready(ready));
  sarcc_asserts i_sarcc_asserts (.clk(clk), .sys_rst(sys_rst),
    .sel_n(bus.sel_n), .rd_conv_n(bus.rd_conv_n), .busy_n(bus.busy_n),
    .byte_swap(bus.byte_swap), .data_out(bus.data_out),
    .data_oe(bus.data_oe));

  function automatic logic [15:0] exp_lanes(input logic [15:0] s, input logic sw);
    exp_lanes = sw ? {s[7:0], s[15:8]} : s;
  endfunction : exp_lanes

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t read %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %0t %s is %b", $time, what, got);
    end
  endtask : chk1

  task automatic close_out;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // count finished conversions
  always @(posedge clk)
    if (conv_done === 1'b1)
      n_done++;

  // the flags that the waits poll
  function automatic logic flag(input int which);
    case (which)
      0: flag = bus.busy_n;
      1: flag = rd_valid;
      default: flag = ready;
    endcase
  endfunction : flag

  // wait for a flag with a bounded count
  task automatic wait_for(input int which, input logic val, input int lim);
    int k;
    k = 0;
    while (flag(which) !== val && k < lim)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk1(flag(which), val, "handshake");
  endtask : wait_for

  task automatic run_one(input logic [15:0] s, input logic m, input logic sw);
    sample = s;
    mode_sel = m;
    swap_req = sw;
    go = 1'b1;
    @(posedge clk);
    #1;
    go = 1'b0;
    wait_for(0, 1'b0, 20);
    chk1(hold, 1'b1, "hold");
    wait_for(1, 1'b1, 1000);
    chk16(rd_data, exp_lanes(s, sw));
    chk1(hold, 1'b0, "hold");
    n_runs++;
    chk1(n_done == n_runs, 1'b1, "conv_done");
    wait_for(2, 1'b1, 200);
  endtask : run_one

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    sys_rst = 1'b1;
    go = 1'b0;
    mode_sel = 1'b0;
    swap_req = 1'b0;
    sample = 16'h0000;
    miscompares = 0;
    n_checks = 0;
    n_runs = 0;
    void'($urandom(32'h1734cfbb));
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk1(bus.busy_n, 1'b1, "busy_n");
    for (int i = 0; i < 8; i++)
      run_one(corner[i%4], i[0], i[2]);
    // reset in mid-conversion, then carry on
    mode_sel = 1'b1;
    go = 1'b1;
    @(posedge clk);
    #1;
    go = 1'b0;
    wait_for(0, 1'b0, 20);
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    chk1(bus.busy_n, 1'b1, "busy_n");
    chk1(hold, 1'b0, "hold");
    chk1(ready, 1'b1, "ready");
    chk16(bus.data_oe, 16'h0000);
    repeat (12)
      run_one(16'($urandom), 1'($urandom), 1'($urandom));
    close_out();
  end

  initial
  begin
    #800000;
    miscompares++;
    close_out();
  end
endmodule : sarcc_test
